//--- timer_cfg_pkg.sv
package timer_cfg_pkg;
   // Register map
   localparam logic [11:0] CFG_OFFSET    = 12'h00C;
   localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
   // Reserved bits 31:26, 16, 12, 8 and 5 never store a one
   localparam logic [31:0] CFG_WRITABLE  = 32'h03FE_EEDF;

   // Field positions inside the configuration word
   localparam int NON_ORTH_BIT    = 25;
   localparam int QUAD_BIT        = 24;
   localparam int EXT_COUNT_BIT   = 23;
   localparam int RELOAD_BIT      = 22;
   localparam int INVERT_BIT      = 21;
   localparam int SET_ONCE_BIT    = 20;
   localparam int RETRIGGER_BIT   = 19;
   localparam int EDGE_LSB        = 17;
   localparam int SOURCE_LSB      = 13;
   localparam int DIVIDER_LSB     = 9;
   localparam int TRG_FILT_LSB    = 6;
   localparam int EXT_FILT_LSB    = 3;
   localparam int EXT_EDGE_LSB    = 1;
   localparam int COUNT_SRC_BIT   = 0;

   // Edge codes, with separate encodings for trigger and external clock selection
   localparam logic [1:0] EDGE_SOFT    = 2'h0;
   localparam logic [1:0] EDGE_RISE    = 2'h1;
   localparam logic [1:0] EDGE_FALL    = 2'h2;
   localparam logic [1:0] EDGE_BOTH    = 2'h3;
   localparam logic [1:0] CLK_RISE     = 2'h0;
   localparam logic [1:0] CLK_FALL     = 2'h1;
   localparam logic [1:0] CLK_BOTH     = 2'h2;

   // Trigger source codes
   localparam logic [2:0] SRC_PIN      = 3'h0;
   localparam logic [2:0] SRC_ALARM_A  = 3'h1;
   localparam logic [2:0] SRC_ALARM_B  = 3'h2;
   localparam logic [2:0] SRC_TAMPER1  = 3'h3;
   localparam logic [2:0] SRC_TAMPER2  = 3'h4;
   localparam logic [2:0] SRC_COMP     = 3'h6;

   // Glitch filter stable periods for codes 01, 10, 11
   localparam logic [3:0] FILT_SHORT   = 4'h2;
   localparam logic [3:0] FILT_MID     = 4'h4;
   localparam logic [3:0] FILT_LONG    = 4'h8;

   // Pin slots in the synchroniser vector
   localparam int PIN_COUNT = 7;
   localparam int PIN_EXT   = 6;

   typedef struct packed {
      logic [31:0]          cfg;
      logic [31:0]          rdata;
      logic [PIN_COUNT-1:0] s1;
      logic [PIN_COUNT-1:0] s2;
      logic [PIN_COUNT-1:0] s3;
      logic [PIN_COUNT-1:0] pin;
      logic                 trg_lvl;
      logic [2:0]           trg_cnt;
      logic                 ext_lvl;
      logic [2:0]           ext_cnt;
      logic [6:0]           pre_cnt;
      logic                 tick;
      logic                 ext_edge;
      logic                 trg_start;
      logic                 trg_restart;
      logic                 arr_pend;
      logic                 cmp_pend;
      logic                 arr_load;
      logic                 cmp_load;
      logic                 wave;
   } timer_cfg_state_t;
endpackage

//--- low_power_timer_config.sv
module low_power_timer_config
   import timer_cfg_pkg::*;
#(
   parameter int ADDR_W = 12
)(
   // Clock and reset
   input  wire logic              CORE_CLK,
   input  wire logic              RESET_N,
   // Peripheral bus
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic [31:0]       PWDATA,
   output      logic [31:0]       PRDATA,
   output      logic              PREADY,
   output      logic              PSLVERR,
   // Counter and compare side
   input  wire logic              TIMER_ON,
   input  wire logic              TIMER_RUNNING,
   input  wire logic              COMPARE_RESULT,
   input  wire logic              PERIOD_END,
   input  wire logic              PERIOD_LIMIT_WRITE,
   input  wire logic              MATCH_VALUE_WRITE,
   // Pins and trigger sources
   input  wire logic              TRIGGER_PIN,
   input  wire logic              RTC_ALARM_A,
   input  wire logic              RTC_ALARM_B,
   input  wire logic              TAMPER_INPUT_ONE,
   input  wire logic              TAMPER_INPUT_TWO,
   input  wire logic              COMPARATOR_OUT,
   input  wire logic              EXT_INPUT_ONE,
   // Decoded modes
   output      logic              NON_ORTHOGONAL_SELECT,
   output      logic              QUADRATURE_MODE_ON,
   output      logic              SET_ONCE_MODE,
   output      logic [1:0]        EXT_CLOCK_EDGE_SELECT,
   // Events and waveform
   output      logic              COUNT_TICK,
   output      logic              EXT_INPUT_EDGE,
   output      logic              TRIGGER_START,
   output      logic              TRIGGER_RESTART,
   output      logic              PERIOD_LIMIT_LOAD,
   output      logic              MATCH_VALUE_LOAD,
   output      logic              TIMER_OUT
);
   import timer_cfg_pkg::*;

   // Upper address bits are compared as a slice, so at least one must exist
   if (ADDR_W < 5) $error("ADDR_W too narrow for the register map");

   timer_cfg_state_t st;
   timer_cfg_state_t next_st;

   logic       hit;
   logic       cfg_write;
   logic [1:0] trg_edge;
   logic [2:0] trg_src;
   logic [2:0] divider;
   logic [1:0] ext_pol;
   logic       trg_in;
   logic       trg_fire;
   logic       ext_rise;
   logic       ext_fall;
   logic [6:0] pre_last;

   // One filter step: a new level is taken after enough stable samples
   function automatic logic [3:0] filter_step(input logic lvl, input logic [2:0] cnt,
                                              input logic in, input logic [1:0] code);
      logic [3:0] need;
      need = (code == 2'h1) ? FILT_SHORT : (code == 2'h2) ? FILT_MID : FILT_LONG;
      if (in == lvl)
         filter_step = {lvl, 3'h0};
      else if (code == 2'h0 || {1'b0, cnt} + 4'h1 >= need)
         filter_step = {in, 3'h0};
      else
         filter_step = {lvl, 3'(cnt + 3'h1)};
   endfunction

   // Field views of the stored configuration
   assign trg_edge = st.cfg[EDGE_LSB +: 2];
   assign trg_src  = st.cfg[SOURCE_LSB +: 3];
   assign divider  = st.cfg[DIVIDER_LSB +: 3];
   assign ext_pol  = st.cfg[EXT_EDGE_LSB +: 2];
   assign hit      = PSEL && PADDR[3:0] == CFG_OFFSET[3:0] && PADDR[ADDR_W-1:4] == '0;
   assign cfg_write = hit && PENABLE && PWRITE && !TIMER_ON;

   // Bus answers in the access phase, never stalls
   assign PREADY  = 1'b1;
   assign PSLVERR = 1'b0;
   assign PRDATA  = st.rdata;

   always_comb
   begin
      next_st = st;
      trg_in = 1'b0;
      if (cfg_write)
         next_st.cfg = PWDATA & CFG_WRITABLE;
      // Read data latched in setup phase so it comes from a flop
      if (PSEL && !PENABLE)
         next_st.rdata = hit ? st.cfg : 32'h0000_0000;

      // Three-flop capture; a change counts once flops two and three agree
      next_st.s1 = {EXT_INPUT_ONE, COMPARATOR_OUT, TAMPER_INPUT_TWO, TAMPER_INPUT_ONE,
                    RTC_ALARM_B, RTC_ALARM_A, TRIGGER_PIN};
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < PIN_COUNT; i++)
      begin
         if (st.s2[i] == st.s3[i])
            next_st.pin[i] = st.s3[i];
      end

      // trigger source, reserved codes never fire
      case (trg_src)
         SRC_PIN:     trg_in = st.pin[0];
         SRC_ALARM_A: trg_in = st.pin[1];
         SRC_ALARM_B: trg_in = st.pin[2];
         SRC_TAMPER1: trg_in = st.pin[3];
         SRC_TAMPER2: trg_in = st.pin[4];
         SRC_COMP:    trg_in = st.pin[5];
         default:     trg_in = st.trg_lvl;
      endcase

      {next_st.trg_lvl, next_st.trg_cnt} =
         filter_step(st.trg_lvl, st.trg_cnt, trg_in, st.cfg[TRG_FILT_LSB +: 2]);
      {next_st.ext_lvl, next_st.ext_cnt} =
         filter_step(st.ext_lvl, st.ext_cnt, st.pin[PIN_EXT], st.cfg[EXT_FILT_LSB +: 2]);

      // edge choice; code 00 leaves starting to software
      case (trg_edge)
         EDGE_RISE: trg_fire = next_st.trg_lvl && !st.trg_lvl;
         EDGE_FALL: trg_fire = !next_st.trg_lvl && st.trg_lvl;
         EDGE_BOTH: trg_fire = next_st.trg_lvl != st.trg_lvl;
         default:   trg_fire = 1'b0;
      endcase
      // running timer restarts only when allowed
      next_st.trg_start   = trg_fire && !TIMER_RUNNING;
      next_st.trg_restart = trg_fire && TIMER_RUNNING && st.cfg[RETRIGGER_BIT];

      // external edge choice, code 11 never counts
      ext_rise = next_st.ext_lvl && !st.ext_lvl;
      ext_fall = !next_st.ext_lvl && st.ext_lvl;
      case (ext_pol)
         CLK_RISE: next_st.ext_edge = ext_rise;
         CLK_FALL: next_st.ext_edge = ext_fall;
         CLK_BOTH: next_st.ext_edge = ext_rise || ext_fall;
         default:  next_st.ext_edge = 1'b0;
      endcase

      // divider is 2 to the power of the code
      pre_last = 7'((8'h01 << divider) - 8'h01);
      if (st.pre_cnt >= pre_last)
         next_st.pre_cnt = 7'h00;
      else
         next_st.pre_cnt = 7'(st.pre_cnt + 7'h01);
      // counting follows input one or the divided clock
      if (st.cfg[EXT_COUNT_BIT] || st.cfg[COUNT_SRC_BIT])
         next_st.tick = next_st.ext_edge;
      else
         next_st.tick = st.pre_cnt >= pre_last;

      // shadow loads, pending writes wait for the period end
      if (st.cfg[RELOAD_BIT])
      begin
         next_st.arr_load = PERIOD_END && (st.arr_pend || PERIOD_LIMIT_WRITE);
         next_st.cmp_load = PERIOD_END && (st.cmp_pend || MATCH_VALUE_WRITE);
         next_st.arr_pend = !PERIOD_END && (st.arr_pend || PERIOD_LIMIT_WRITE);
         next_st.cmp_pend = !PERIOD_END && (st.cmp_pend || MATCH_VALUE_WRITE);
      end
      else
      begin
         next_st.arr_load = PERIOD_LIMIT_WRITE;
         next_st.cmp_load = MATCH_VALUE_WRITE;
         next_st.arr_pend = 1'b0;
         next_st.cmp_pend = 1'b0;
      end

      next_st.wave = COMPARE_RESULT ^ st.cfg[INVERT_BIT];
   end

   // All state in one register
   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         st <= '0;
      else
         st <= next_st;
   end

   // mode bits straight from the register
   assign NON_ORTHOGONAL_SELECT = st.cfg[NON_ORTH_BIT];
   assign QUADRATURE_MODE_ON    = st.cfg[QUAD_BIT];
   assign SET_ONCE_MODE         = st.cfg[SET_ONCE_BIT];
   assign EXT_CLOCK_EDGE_SELECT = ext_pol;
   assign COUNT_TICK            = st.tick;
   assign EXT_INPUT_EDGE        = st.ext_edge;
   assign TRIGGER_START         = st.trg_start;
   assign TRIGGER_RESTART       = st.trg_restart;
   assign PERIOD_LIMIT_LOAD     = st.arr_load;
   assign MATCH_VALUE_LOAD      = st.cmp_load;
   assign TIMER_OUT             = st.wave;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);

   sequence s_write_on;
      PSEL && PENABLE && PWRITE && hit && TIMER_ON;
   endsequence
   sequence s_write_off;
      cfg_write;
   endsequence

   a_write_blocked: assert property (s_write_on |=> $stable(st.cfg))
      else $error("configuration changed while timer on");
   a_non_orth_set: assert property (s_write_off |=> NON_ORTHOGONAL_SELECT == $past(PWDATA[25]))
      else $error("non-orthogonal bit not stored");
   a_quad_set: assert property (s_write_off |=> QUADRATURE_MODE_ON == $past(PWDATA[24]))
      else $error("encoder bit not stored");
   a_reserved_zero: assert property ((st.cfg & ~CFG_WRITABLE) == 32'h0000_0000)
      else $error("reserved bit stored as one");
   a_div_two: assert property ((divider == 3'h1 && !st.cfg[EXT_COUNT_BIT] && !st.cfg[COUNT_SRC_BIT]
      && COUNT_TICK && !cfg_write) |=> !COUNT_TICK ##1 COUNT_TICK)
      else $error("divide by two tick spacing wrong");
   a_period_hold: assert property ((st.cfg[RELOAD_BIT] && !PERIOD_END) |=> !PERIOD_LIMIT_LOAD)
      else $error("shadow load outside period end");
   a_out_invert: assert property (##1 TIMER_OUT == $past(COMPARE_RESULT ^ st.cfg[INVERT_BIT]))
      else $error("timer output polarity wrong");
   a_soft_start: assert property ((trg_edge == EDGE_SOFT) |=> !TRIGGER_START && !TRIGGER_RESTART)
      else $error("hardware trigger in software mode");
   a_restart_gate: assert property (TRIGGER_RESTART |-> $past(st.cfg[RETRIGGER_BIT] && TIMER_RUNNING))
      else $error("restart without retrigger enable");
   a_filter_long: assert property ((st.cfg[TRG_FILT_LSB +: 2] == 2'h3 && $changed(st.trg_lvl)
      && $past(st.cfg[TRG_FILT_LSB +: 2]) == 2'h3) |-> $past(st.trg_cnt) == 3'h7)
      else $error("trigger accepted before eight stable periods");
endmodule

//--- low_power_timer_config_test.sv
module low_power_timer_config_test;
   timeunit 1ns;
   timeprecision 1ps;
   import timer_cfg_pkg::*;

   // Bench drives, all set at time zero
   logic        clk = 0;
   logic        rst_n = 0;
   logic        psel = 0;
   logic        pen = 0;
   logic        pwr = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic        ton = 0;
   logic        trun = 0;
   logic        cmp = 0;
   logic        pend = 0;
   logic        lwr = 0;
   logic        mwr = 0;
   logic        ext = 0;
   logic [7:0]  src = '0;
   // Design outputs
   logic [31:0] prdata;
   logic [1:0]  eesel;
   logic        pready, pslverr, non_orthogonal_select, quad, once, tick, extedge;
   logic        tstart, trest, lload, mload, tout;
   // Pulse counters: tick, ext edge, start, restart, loads
   int          cnt [6];
   int          fail_count = 0;
   int          n_compared = 0;
   // Reserved bits 31:26, 16, 12, 8, 5 read back as zero
   localparam logic [31:0] KEEP = 32'h03FF_FFFF & ~32'h0001_1120;

   always #5 clk = ~clk;

   low_power_timer_config i_low_power_timer_config (
      .CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .TIMER_ON(ton), .TIMER_RUNNING(trun), .COMPARE_RESULT(cmp),
      .PERIOD_END(pend), .PERIOD_LIMIT_WRITE(lwr), .MATCH_VALUE_WRITE(mwr),
      .TRIGGER_PIN(src[0]), .RTC_ALARM_A(src[1]), .RTC_ALARM_B(src[2]),
      .TAMPER_INPUT_ONE(src[3]), .TAMPER_INPUT_TWO(src[4]), .COMPARATOR_OUT(src[6]),
      .EXT_INPUT_ONE(ext), .NON_ORTHOGONAL_SELECT(non_orthogonal_select), .QUADRATURE_MODE_ON(quad),
      .SET_ONCE_MODE(once), .EXT_CLOCK_EDGE_SELECT(eesel), .COUNT_TICK(tick),
      .EXT_INPUT_EDGE(extedge), .TRIGGER_START(tstart), .TRIGGER_RESTART(trest),
      .PERIOD_LIMIT_LOAD(lload), .MATCH_VALUE_LOAD(mload), .TIMER_OUT(tout));

   // Counted on the falling edge, away from the launching edge
   always @(negedge clk)
   begin
      cnt[0] += tick;
      cnt[1] += extedge;
      cnt[2] += tstart;
      cnt[3] += trest;
      cnt[4] += lload;
      cnt[5] += mload;
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task give_verdict;
      if (fail_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, pen, pwr, paddr, pwdata} <= {3'b101, a, d};
      @(posedge clk);
      pen <= 1;
      @(posedge clk);
      {psel, pen} <= 2'b00;
   endtask

   // Read data holds through the access phase, so sampling at its end is safe
   task rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      {psel, pen, pwr, paddr} <= {3'b100, a};
      @(posedge clk);
      pen <= 1;
      @(posedge clk);
      check(prdata, exp);
      check(pready, 1);
      check(pslverr, 0);
      {psel, pen} <= 2'b00;
   endtask

   task cfg(input logic [31:0] v);
      wr(CFG_OFFSET, v);
      repeat (4) @(posedge clk);
      cnt = '{default: 0};
   endtask

   // Level pulse of w cycles on a source, then a long quiet gap
   task pulse(input int code, input int w, input bit on_ext);
      @(posedge clk);
      if (on_ext)
         ext <= 1;
      else
         src[code] <= 1;
      repeat (w) @(posedge clk);
      ext <= 0;
      src <= '0;
      repeat (20) @(posedge clk);
   endtask

   // Expected edges for one pulse; filters need n stable samples
   function automatic int edges(input int code, input int w, input int n, input bit xc);
      int e;
      if (xc)
         e = (code == 3) ? 0 : (code == 2) ? 2 : 1;
      else
         e = (code == 0) ? 0 : (code == 3) ? 2 : 1;
      return (w < n) ? 0 : e;
   endfunction

   initial
   begin
      #900_000;
      fail_count++;
      give_verdict;
   end

   initial
   begin
      logic [31:0] d;
      logic        r;
      bit          exp_q [$];
      void'($urandom(32'h2139e600));
      repeat (10) @(posedge clk);
      rst_n <= 1;
      rd(CFG_OFFSET, CFG_RESET);
      // Random configurations, decoded modes and output polarity
      for (int i = 0; i < 8; i++)
      begin
         d = $urandom;
         cfg(d);
         rd(CFG_OFFSET, d & KEEP);
         check({non_orthogonal_select, quad, once, eesel}, {d[25], d[24], d[20], d[2:1]});
         for (int k = 0; k < 6; k++)
         begin
            @(posedge clk);
            r = 1'($urandom);
            cmp <= r;
            @(negedge clk);
            if (k > 0)
               check(tout, exp_q.pop_front());
            exp_q.push_back(r ^ d[21]);
         end
         exp_q.delete();
      end
      // Locked while timer on, unmapped place ignored
      @(posedge clk);
      ton <= 1;
      wr(CFG_OFFSET, ~d);
      ton <= 0;
      wr(12'h010, '1);
      rd(12'h010, 0);
      rd(CFG_OFFSET, d & KEEP);
      // Divider ratios
      for (int c = 0; c < 8; c++)
      begin
         cfg(c << 9);
         repeat (256) @(posedge clk);
         cnt = '{default: 0};
         repeat (256) @(posedge clk);
         check(cnt[0], 256 >> c);
      end
      // Every trigger source against every edge code
      for (int s = 0; s < 8; s++)
         for (int e = 0; e < 4; e++)
         begin
            cfg(e << 17 | s << 13);
            pulse((s == 5 || s == 7) ? 0 : s, 12, 0);
            check(cnt[2], (s == 5 || s == 7) ? 0 : edges(e, 12, 1, 0));
         end
      // Glitch filters at the boundary width
      for (int f = 1; f < 4; f++)
         for (int w = (1 << f) - 1; w <= (1 << f); w++)
         begin
            cfg(3 << 17 | f << 6);
            pulse(0, w, 0);
            check(cnt[2], edges(3, w, 1 << f, 0));
            cfg(1 << 23 | f << 3 | 2 << 1);
            pulse(0, w, 1);
            check(cnt[1], edges(2, w, 1 << f, 1));
            check(cnt[0], edges(2, w, 1 << f, 1));
         end
      // External clock edge codes with count source bit
      for (int c = 0; c < 4; c++)
      begin
         cfg(1 | c << 1);
         pulse(0, 12, 1);
         check(cnt[1], edges(c, 12, 1, 1));
         check(cnt[0], edges(c, 12, 1, 1));
      end
      // Triggers while already running
      trun <= 1;
      for (int t = 0; t < 2; t++)
      begin
         cfg(t << 19 | 1 << 17);
         pulse(0, 12, 0);
         check(cnt[3], t);
         check(cnt[2], 0);
      end
      trun <= 0;
      // Shadow loads on write or at period end, pending cleared once used
      for (int t = 0; t < 2; t++)
      begin
         cfg(t << 22);
         @(posedge clk);
         {lwr, mwr} <= 2'b11;
         @(posedge clk);
         {lwr, mwr} <= 2'b00;
         repeat (4) @(posedge clk);
         check(cnt[4], t ? 0 : 1);
         check(cnt[5], t ? 0 : 1);
         for (int p = 0; p < 2; p++)
         begin
            @(posedge clk);
            pend <= 1;
            @(posedge clk);
            pend <= 0;
            repeat (3) @(posedge clk);
         end
         check(cnt[4], 1);
         check(cnt[5], 1);
      end
      // Mid-run reset; compare input parked low so the output check stays quiet
      @(posedge clk);
      cmp <= 0;
      rst_n <= 0;
      repeat (3) @(posedge clk);
      rst_n <= 1;
      rd(CFG_OFFSET, CFG_RESET);
      give_verdict;
   end
endmodule
